// >>> verilog/aif_pkg.sv
`default_nettype none
package aif_pkg;
    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int          AIF_DW      = 16;
    localparam int          AIF_AW      = 4;
    localparam int          AIF_NCH     = 4;
    localparam int          AIF_NEOC    = 16;
    localparam int          AIF_SELW    = 4;
    localparam int          AIF_CFGW    = 8;

    // ------------------------------------------------------------------
    // Register offsets (word index on the register port)
    // ------------------------------------------------------------------
    localparam logic [3:0]  AIF_OFS_FLAG     = 4'h3;
    localparam logic [3:0]  AIF_OFS_FLAG_CLR = 4'h4;
    localparam logic [3:0]  AIF_OFS_OVF      = 4'h5;
    localparam logic [3:0]  AIF_OFS_OVF_CLR  = 4'h6;
    localparam logic [3:0]  AIF_OFS_SEL_LO   = 4'h7;
    localparam logic [3:0]  AIF_OFS_SEL_HI   = 4'h8;
    localparam logic [3:0]  AIF_OFS_IRQ_STAT = 4'hA;
    localparam logic [3:0]  AIF_OFS_IRQ_MASK = 4'hB;

    // ------------------------------------------------------------------
    // Selection byte layout
    // ------------------------------------------------------------------
    localparam int          AIF_SEL_LSB  = 0;
    localparam int          AIF_ENA_BIT  = 5;
    localparam int          AIF_CONT_BIT = 6;
    localparam logic [7:0]  AIF_CFG_WMASK = 8'h6F;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] AIF_RST_WORD = 16'h0000;
    localparam logic [3:0]  AIF_RST_NIB  = 4'h0;
    localparam logic [7:0]  AIF_RST_CFG  = 8'h00;

    // ------------------------------------------------------------------
    // Per-channel state kept by the channel module
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AIF_CH_IDLE,
        AIF_CH_FLAGGED
    } aif_ch_state_t;
endpackage
`default_nettype wire

// >>> verilog/aif_channel.sv
`timescale 1ns/10ps
`default_nettype none
module aif_channel (
    input  wire logic       clk_sys,
    input  wire logic       rst_sync_n,
    input  wire logic       clk_en,
    input  wire logic [7:0] cfg,
    input  wire logic [15:0] eoc,
    input  wire logic       flag_clr,
    input  wire logic       ovf_clr,
    output logic            irq_pulse,
    output logic            flag,
    output logic            ovf
);
    // ------------------------------------------------------------------
    // Event pick and decision
    // ------------------------------------------------------------------
    aif_pkg::aif_ch_state_t state;
    aif_pkg::aif_ch_state_t next_state;
    logic                   next_ovf;
    logic                   next_irq_pulse;
    logic                   enabled;
    logic                   cont;
    logic                   hit;

    // Decode the channel byte
    always_comb begin
        enabled = cfg[aif_pkg::AIF_ENA_BIT];
        cont    = cfg[aif_pkg::AIF_CONT_BIT];
        hit     = enabled && eoc[cfg[aif_pkg::AIF_SEL_LSB +: aif_pkg::AIF_SELW]]; // RQ10 RQ14
    end

    // Next flag, overflow and pulse
    always_comb begin
        next_state     = state;
        next_ovf       = ovf;
        next_irq_pulse = 1'b0;
        if (flag_clr) begin
            next_state = aif_pkg::AIF_CH_IDLE; // RQ1
        end
        if (ovf_clr) begin
            next_ovf = 1'b0; // RQ5
        end
        case (state)
            aif_pkg::AIF_CH_IDLE: begin
                if (hit) begin
                    next_state     = aif_pkg::AIF_CH_FLAGGED; // RQ2 RQ13
                    next_irq_pulse = 1'b1;
                end
            end
            aif_pkg::AIF_CH_FLAGGED: begin
                if (hit && flag_clr) begin
                    // Hardware set beats the clear: fresh flag, no overflow
                    next_state     = aif_pkg::AIF_CH_FLAGGED; // RQ2
                    next_irq_pulse = 1'b1; // RQ2 RQ13
                end else if (hit) begin
                    next_ovf       = 1'b1; // RQ3 RQ4 RQ6
                    next_irq_pulse = cont; // RQ7 RQ8
                end
            end
            default: begin
                next_state = aif_pkg::AIF_CH_IDLE;
            end
        endcase
    end

    // Register channel state
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state     <= aif_pkg::AIF_CH_IDLE;
            ovf       <= 1'b0;
            irq_pulse <= 1'b0;
        end else if (clk_en) begin
            state     <= next_state;
            ovf       <= next_ovf;
            irq_pulse <= next_irq_pulse;
        end
    end

    assign flag = (state == aif_pkg::AIF_CH_FLAGGED);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_flag_set_hit: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RQ2
        (clk_en && hit) |=> flag)
        else $error("flag not set after selected event");
    a_ovf_on_repeat: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RQ3
        (clk_en && hit && flag && !flag_clr) |=> ovf)
        else $error("overflow not set on repeat event");
    a_clr_hit_keep: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RQ2
        (clk_en && hit && flag && flag_clr && !ovf) |=> flag && !ovf && irq_pulse)
        else $error("flag clear beside event lost flag or set overflow");
    a_no_ovf_first: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RQ2
        (clk_en && hit && !flag && !ovf) |=> !ovf)
        else $error("overflow set on first event");
    a_hold_pulse: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RQ7
        (clk_en && flag && !cont && !flag_clr) |=> !irq_pulse)
        else $error("pulse emitted while flagged without continue");
    a_cont_pulse: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RQ8
        (clk_en && hit) |=> irq_pulse || (!$past(cont) && $past(flag)))
        else $error("continue mode pulse missing");
    a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RQ14
        (clk_en && !enabled && !flag) |=> !flag && !irq_pulse)
        else $error("disabled channel became active");
endmodule
`default_nettype wire

// >>> verilog/aif_top.sv
//
// Overview of operation
// RQ1 - Writing one to flag clear bit clears that channel flag; reads zero.
// RQ2 - Event and flag clear together: flag stays set, overflow untouched.
// RQ3 - Event while flag already set sets that channel's overflow bit.
// RQ4 - Overflow detection ignores continue mode.
// RQ5 - Writing one to overflow clear bit clears overflow; reads zero.
// RQ6 - Overflow set and clear together: overflow ends set.
// RQ7 - Continue off: no more pulses until flag cleared.
// RQ8 - Continue on: pulse on every selected event.
// RQ9 - Per-channel enable bit gates the interrupt.
// RQ10 - Four-bit field picks one of sixteen events as trigger.
// RQ11 - Channels one, two at offset 7; three, four at offset 8.
// RQ12 - Reset clears all registers: channels disabled, event zero chosen.
// RQ13 - Flag reads one once a pulse was made since last clear.
// RQ14 - Disabled channel makes no pulse, flag or overflow.
//
`timescale 1ns/10ps
`default_nettype none
module aif_top (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [15:0] eoc,
    output logic      [3:0]  irq_pulse,
    output logic             irq
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_n;
    logic rst_sync_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] ofs,
                                    input logic we);
        wr_hit = we && (a == ofs);
    endfunction

    logic [7:0]  cfg [4];
    logic [7:0]  next_cfg [4];
    logic [3:0]  mask;
    logic [3:0]  next_mask;
    logic [3:0]  stat;
    logic [3:0]  next_stat;
    logic [15:0] next_rdata;
    logic [3:0]  flag;
    logic [3:0]  ovf;
    logic [3:0]  flag_clr;
    logic [3:0]  ovf_clr;
    logic [3:0]  ch_pulse;
    logic [3:0]  ovf_q;
    logic [3:0]  next_ovf_q;

    // Write-one-to-clear strobes, decoded from the write alone; channels act on them only in an enabled cycle
    always_comb begin
        flag_clr = {4{wr_hit(reg_addr, aif_pkg::AIF_OFS_FLAG_CLR, reg_wr)}}
                   & reg_wdata[3:0]; // RQ1
        ovf_clr  = {4{wr_hit(reg_addr, aif_pkg::AIF_OFS_OVF_CLR, reg_wr)}}
                   & reg_wdata[3:0]; // RQ5
    end

    // Selection and interrupt registers
    always_comb begin
        next_cfg  = cfg;
        next_mask = mask;
        if (wr_hit(reg_addr, aif_pkg::AIF_OFS_SEL_LO, reg_wr)) begin
            next_cfg[0] = reg_wdata[7:0] & aif_pkg::AIF_CFG_WMASK; // RQ11 RQ9
            next_cfg[1] = reg_wdata[15:8] & aif_pkg::AIF_CFG_WMASK; // RQ11
        end
        if (wr_hit(reg_addr, aif_pkg::AIF_OFS_SEL_HI, reg_wr)) begin
            next_cfg[2] = reg_wdata[7:0] & aif_pkg::AIF_CFG_WMASK; // RQ11
            next_cfg[3] = reg_wdata[15:8] & aif_pkg::AIF_CFG_WMASK; // RQ11
        end
        if (wr_hit(reg_addr, aif_pkg::AIF_OFS_IRQ_MASK, reg_wr)) begin
            next_mask = reg_wdata[3:0];
        end
    end

    // Sticky status: pulse or new overflow sets, write one clears, set wins
    always_comb begin
        next_ovf_q = ovf;
        next_stat  = stat;
        if (wr_hit(reg_addr, aif_pkg::AIF_OFS_IRQ_STAT, reg_wr)) begin
            next_stat = stat & ~reg_wdata[3:0];
        end
        next_stat = next_stat | ch_pulse | (ovf & ~ovf_q);
    end

    // Read mux, data one cycle after the strobe
    always_comb begin
        next_rdata = aif_pkg::AIF_RST_WORD;
        if (reg_rd) begin
            case (reg_addr)
                aif_pkg::AIF_OFS_FLAG:     next_rdata = {12'h000, flag}; // RQ13
                aif_pkg::AIF_OFS_OVF:      next_rdata = {12'h000, ovf}; // RQ3
                aif_pkg::AIF_OFS_SEL_LO:   next_rdata = {cfg[1], cfg[0]};
                aif_pkg::AIF_OFS_SEL_HI:   next_rdata = {cfg[3], cfg[2]};
                aif_pkg::AIF_OFS_IRQ_STAT: next_rdata = {12'h000, stat};
                aif_pkg::AIF_OFS_IRQ_MASK: next_rdata = {12'h000, mask};
                default:                   next_rdata = aif_pkg::AIF_RST_WORD; // RQ1 RQ5
            endcase
        end
    end

    // Register file storage
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < aif_pkg::AIF_NCH; i++) begin
                cfg[i] <= aif_pkg::AIF_RST_CFG; // RQ12
            end
            mask      <= aif_pkg::AIF_RST_NIB;
            stat      <= aif_pkg::AIF_RST_NIB;
            ovf_q     <= aif_pkg::AIF_RST_NIB;
            reg_rdata <= aif_pkg::AIF_RST_WORD;
        end else if (clk_en) begin
            cfg       <= next_cfg;
            mask      <= next_mask;
            stat      <= next_stat;
            ovf_q     <= next_ovf_q;
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    for (genvar c = 0; c < aif_pkg::AIF_NCH; c++) begin : g_ch
        aif_channel u_ch (
            .clk_sys    (clk_sys),
            .rst_sync_n (rst_sync_n),
            .clk_en     (clk_en),
            .cfg        (cfg[c]),
            .eoc        (eoc),
            .flag_clr   (flag_clr[c]),
            .ovf_clr    (ovf_clr[c]),
            .irq_pulse  (ch_pulse[c]),
            .flag       (flag[c]),
            .ovf        (ovf[c])
        );
    end

    // Outputs
    assign irq_pulse = ch_pulse;
    assign irq       = |(stat & mask);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_clr_flag0;
        clk_en && reg_wr && reg_addr == aif_pkg::AIF_OFS_FLAG_CLR && reg_wdata[0];
    endsequence

    a_flag_clear_one: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RQ1
        (s_clr_flag0 and !(cfg[0][aif_pkg::AIF_ENA_BIT] && eoc[cfg[0][3:0]])) |=> !flag[0])
        else $error("flag clear write did not clear");
    a_ovf_clear_one: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RQ5
        (clk_en && reg_wr && reg_addr == aif_pkg::AIF_OFS_OVF_CLR && reg_wdata[1]
         && !(flag[1] && cfg[1][aif_pkg::AIF_ENA_BIT] && eoc[cfg[1][3:0]])) |=> !ovf[1])
        else $error("overflow clear write did not clear");
    a_ovf_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RQ6
        (clk_en && reg_wr && reg_addr == aif_pkg::AIF_OFS_OVF_CLR && reg_wdata[0]
         && flag[0] && cfg[0][aif_pkg::AIF_ENA_BIT] && eoc[cfg[0][3:0]]) |=> ovf[0])
        else $error("overflow clear beat hardware set");
    a_clr_reads_zero: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RQ1
        (clk_en && reg_rd && (reg_addr == aif_pkg::AIF_OFS_FLAG_CLR
         || reg_addr == aif_pkg::AIF_OFS_OVF_CLR)) |=> reg_rdata == 16'h0000)
        else $error("clear register read not zero");
    a_sel_readback: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RQ11
        (clk_en && reg_wr && reg_addr == aif_pkg::AIF_OFS_SEL_HI) ##1
        (clk_en && reg_rd && reg_addr == aif_pkg::AIF_OFS_SEL_HI && !reg_wr)
        |=> reg_rdata == ($past(reg_wdata, 2) & {aif_pkg::AIF_CFG_WMASK, aif_pkg::AIF_CFG_WMASK}))
        else $error("select register readback wrong");
endmodule
`default_nettype wire

// >>> tb/aif_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module aif_cpu_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [3:0]  irq_pulse,
    output logic      [15:0] pulse_cnt
);
    // ------------------------------------------------------------------
    // Pulse counters, four bits per channel, channel 1 lowest
    // ------------------------------------------------------------------
    logic [15:0] next_pulse_cnt;

    // Add one per received pulse; a one-cycle pulse must not be missed
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_pulse_cnt[i*4 +: 4] = pulse_cnt[i*4 +: 4] + {3'h0, irq_pulse[i]};
        end
    end

    // Register the counts
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt <= 16'h0000;
        end else begin
            pulse_cnt <= next_pulse_cnt;
        end
    end
endmodule
`default_nettype wire

// >>> tb/aif_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module aif_top_bench;
    // ------------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------------
    logic        clk_sys;
    logic        rst_n;
    logic        clk_en;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic [15:0] eoc;
    logic [3:0]  irq_pulse;
    logic        irq;
    logic [15:0] pulse_cnt;
    int          errors;
    int          cmp_count;
    logic [3:0]  rst_addrs [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hB, 4'hC};

    aif_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
                 .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
                 .reg_rdata(reg_rdata), .eoc(eoc), .irq_pulse(irq_pulse), .irq(irq));

    aif_cpu_model cpu (.clk_sys(clk_sys), .rst_n(rst_n), .irq_pulse(irq_pulse),
                       .pulse_cnt(pulse_cnt));

    // ------------------------------------------------------------------
    // Bus and event tasks
    // ------------------------------------------------------------------
    // Compare one value, count it, report a mismatch
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One write cycle, optionally with events in the same cycle
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        eoc       <= e;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        eoc       <= 16'h0000;
        #1;
    endtask

    // One read cycle, data checked in the cycle after the strobe
    task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
    endtask

    // One event cycle, then check the pulses of the following cycle
    task automatic fire(input logic [15:0] e, input logic [3:0] exp);
        @(posedge clk_sys);
        eoc <= e;
        @(posedge clk_sys);
        eoc <= 16'h0000;
        #1;
        chk("irq_pulse", {12'h000, exp}, {12'h000, irq_pulse});
    endtask

    // Counts, verdict and end of run
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, reset and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Cut a hang short
    initial begin
        #200000;
        errors++;
        give_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0; clk_en = 1'b1; reg_addr = 4'h0; reg_wdata = 16'h0000;
        reg_wr = 1'b0; reg_rd = 1'b0; eoc = 16'h0000; errors = 0; cmp_count = 0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        // Reset values, unmapped place included
        foreach (rst_addrs[i]) rd_chk("reset word", rst_addrs[i], 16'h0000);
        // Select layout, reserved bits read zero
        wr_reg(4'h7, 16'hFFFF, 16'h0000);
        rd_chk("select low", 4'h7, 16'h6F6F);
        wr_reg(4'h7, 16'h6523, 16'h0000);
        rd_chk("select low", 4'h7, 16'h6523);
        wr_reg(4'h8, 16'h2F0F, 16'h0000);
        rd_chk("select high", 4'h8, 16'h2F0F);
        wr_reg(4'hB, 16'h000F, 16'h0000);
        // Sources by number; disabled channel three stays quiet
        fire(16'h7FFF, 4'h3);
        fire(16'h8000, 4'h8);
        rd_chk("flags", 4'h3, 16'h000B);
        rd_chk("overflow", 4'h5, 16'h0000);
        chk("irq", 16'h0001, {15'h0000, irq});
        // Repeat without continue mode: overflow, no pulse
        fire(16'h0008, 4'h0);
        rd_chk("overflow", 4'h5, 16'h0001);
        // Continue mode keeps pulsing and still overflows
        fire(16'h0020, 4'h2);
        rd_chk("overflow", 4'h5, 16'h0003);
        chk("pulse counts", 16'h1021, pulse_cnt);
        // Overflow clear
        wr_reg(4'h6, 16'h0001, 16'h0000);
        rd_chk("overflow clear", 4'h6, 16'h0000);
        rd_chk("overflow", 4'h5, 16'h0002);
        // Flag clear
        wr_reg(4'h4, 16'h0008, 16'h0000);
        rd_chk("flag clear", 4'h4, 16'h0000);
        rd_chk("flags", 4'h3, 16'h0003);
        wr_reg(4'h4, 16'h0001, 16'h0000);
        rd_chk("flags", 4'h3, 16'h0002);
        // Flag clear and set in one cycle
        wr_reg(4'h4, 16'h0001, 16'h0008);
        chk("irq_pulse", 16'h0001, {12'h000, irq_pulse});
        rd_chk("flags", 4'h3, 16'h0003);
        rd_chk("overflow", 4'h5, 16'h0002);
        // Clear while flagged beside a new event: flag kept, pulse, no overflow
        wr_reg(4'h4, 16'h0001, 16'h0008);
        chk("irq_pulse", 16'h0001, {12'h000, irq_pulse});
        rd_chk("flags", 4'h3, 16'h0003);
        rd_chk("overflow", 4'h5, 16'h0002);
        // Overflow clear and set in one cycle
        wr_reg(4'h6, 16'h0001, 16'h0008);
        rd_chk("overflow", 4'h5, 16'h0003);
        // Interrupt status, mask and clear
        wr_reg(4'hA, 16'h000F, 16'h0000);
        rd_chk("irq status", 4'hA, 16'h0000);
        chk("irq", 16'h0000, {15'h0000, irq});
        wr_reg(4'hB, 16'h0001, 16'h0000);
        fire(16'h0020, 4'h2);
        rd_chk("irq status", 4'hA, 16'h0002);
        chk("irq", 16'h0000, {15'h0000, irq});
        wr_reg(4'hB, 16'h000F, 16'h0000);
        chk("irq", 16'h0001, {15'h0000, irq});
        wr_reg(4'hA, 16'h0002, 16'h0000);
        chk("irq", 16'h0000, {15'h0000, irq});
        // Clock enable low freezes the channels: event is lost
        clk_en <= 1'b0;
        fire(16'h0020, 4'h0);
        clk_en <= 1'b1;
        rd_chk("irq status", 4'hA, 16'h0000);
        chk("pulse counts", 16'h1033, pulse_cnt);
        // Reset in mid-run returns every register to zero
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        foreach (rst_addrs[i]) rd_chk("reset word", rst_addrs[i], 16'h0000);
        chk("irq", 16'h0000, {15'h0000, irq});
        give_verdict();
    end
endmodule
`default_nettype wire
